// [core/ffse_dev.sv]
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
module ffse_dev
(
	// Host link
	ffse_if.dev       link,
	// Write path to encoder
	input  wire logic       wr_take_i,
	output logic            wr_en_o,
	output logic [2:0]      wr_field_o,
	output logic [7:0]      wr_byte_o,
	// Read path from separator and drive
	input  wire logic       index_i,
	input  wire logic       rd_id_i,
	input  wire logic [7:0] rd_sec_i,
	input  wire logic       rd_del_i,
	input  wire logic       rd_valid_i,
	input  wire logic [7:0] rd_byte_i
);
	import ffse_pkg::*;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_WIDX  = 7'h02,
		S_FREQ  = 7'h04,
		S_FWR   = 7'h08,
		S_SSEC  = 7'h10,
		S_SBYTE = 7'h20,
		S_DONE  = 7'h40
	} ffse_state_e;

	ffse_state_e st_q;
	logic [1:0]  cmd_q;
	logic [2:0]  n_q;
	logic [7:0]  spt_q, gpl_q, fill_q, r_q, eot_q, stp_q, secs_q, hb_q;
	logic        sk_q, nd_q, mfm_q, drq_q, irq_q, hbv_q, fail_q, strict_q;
	logic        started_q, abn_q, ovr_q, sh_q, sn_q, cm_q;
	logic [1:0]  idx_q, ip_q;
	logic [2:0]  fld_q;
	logic [13:0] cnt_q;
	logic [11:0] tmr_q;
	logic [7:0]  id_q [4];

	////////////////////////////////////////////////////////////////
	// Decode
	wire         clock_i_w = link.clock_i;
	wire         req_w    = drq_q | irq_q;
	wire         took_w   = req_w & link.ack;
	wire [13:0]  size_w   = ffse_sec_bytes(n_q);
	wire [7:0]   gap_w    = mfm_q ? GAP_MFM : GAP_FM;
	wire [1:0]   cmp_w    = ffse_cmp(cmd_q, rd_byte_i, hb_q);
	wire         fail_n   = fail_q | cmp_w[1];
	wire         strict_n = strict_q | cmp_w[0];
	wire [7:0]   r_next   = r_q + stp_q;
	wire [11:0]  ovr_lim  = mfm_q ? OVR_MFM_CYC : OVR_FM_CYC;
	wire [7:0]   cur_w    = (fld_q == FLD_IDAM) ? AM_ID :
	                        (fld_q == FLD_ID)   ? id_q[ip_q] :
	                        (fld_q == FLD_DAM)  ? AM_DATA :
	                        (fld_q == FLD_DATA) ? fill_q : gap_w;
	wire [13:0]  gpl_w    = (gpl_q == 8'h00) ? 14'h0001 : {6'h00, gpl_q};

	assign link.cmd_ready = st_q[0];

	////////////////////////////////////////////////////////////////
	// Encoder outputs, one cycle behind the field counters
	always_ff @(posedge clock_i_w) begin
		if (link.rst_i) begin
			{wr_en_o, wr_field_o, wr_byte_o} <= '0;
		end else begin
			wr_en_o    <= (st_q == S_FWR);
			wr_field_o <= fld_q;
			wr_byte_o  <= cur_w;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command sequencer
	always_ff @(posedge clock_i_w) begin
		if (link.rst_i) begin
			st_q <= S_IDLE;
			{cmd_q, n_q, spt_q, gpl_q, fill_q, r_q, eot_q, stp_q, secs_q, hb_q} <= '0;
			{sk_q, nd_q, mfm_q, drq_q, irq_q, hbv_q, fail_q, strict_q} <= '0;
			{started_q, abn_q, ovr_q, sh_q, sn_q, cm_q} <= '0;
			{idx_q, ip_q, fld_q, cnt_q, tmr_q} <= '0;
			id_q <= '{default: 8'h00};
			{link.dma_req, link.int_req, link.done} <= '0;
			{link.st0, link.st1, link.st2, link.res_sector} <= '0;
		end else begin
			{link.done, link.dma_req, link.int_req} <= {1'b0, drq_q, irq_q};
			{drq_q, irq_q} <= took_w ? 2'b00 : {drq_q, irq_q};
			case (st_q)
			S_IDLE: begin
				if (link.cmd_valid) begin
					{cmd_q, spt_q} <= {link.cmd, link.sectors_per_track};
					{gpl_q, fill_q, r_q} <= {link.gap_length, link.fill, link.sector};
					{eot_q, stp_q} <= {link.end_of_track_sector, link.sector_step};
					{sk_q, nd_q, mfm_q} <= {link.skip_deleted_select, link.non_dma_select, link.mfm};
					n_q <= link.size_code[2:0];
					{idx_q, secs_q, started_q, abn_q, ovr_q, sh_q, sn_q, cm_q} <= '0;
					if (link.mfm && link.size_code == 8'h00) begin
						abn_q <= 1'b1;
						st_q  <= S_DONE;
					end else if (link.cmd == CMD_FMT) begin
						st_q <= S_WIDX;
					end else begin
						st_q <= S_SSEC;
					end
				end
			end
			S_WIDX: begin
				if (index_i) begin
					{idx_q, ip_q} <= {2'h1, 2'h0};
					{drq_q, irq_q} <= {~nd_q, nd_q};
					st_q  <= S_FREQ;
				end
			end
			S_FREQ: begin
				if (index_i) begin
					st_q <= S_DONE;
				end else if (took_w) begin
					id_q[ip_q] <= link.hbyte;
					ip_q <= ip_q + 2'h1;
					if (ip_q == 2'h3) begin
						fld_q <= FLD_IDAM;
						st_q  <= S_FWR;
					end else begin
						{drq_q, irq_q} <= {~nd_q, nd_q};
					end
				end
			end
			S_FWR: begin
				if (index_i) begin
					idx_q <= idx_q + 2'h1;
					st_q  <= S_DONE;
				end else if (wr_take_i) begin
					case (fld_q)
					FLD_IDAM: {fld_q, ip_q} <= {FLD_ID, 2'h0};
					FLD_ID: begin
						ip_q  <= ip_q + 2'h1;
						fld_q <= (ip_q == 2'h3) ? FLD_DAM : FLD_ID;
					end
					FLD_DAM: {fld_q, cnt_q} <= {FLD_DATA, size_w};
					FLD_DATA: begin
						cnt_q <= cnt_q - 14'h0001;
						if (cnt_q == 14'h0001) begin
							fld_q <= FLD_GAP;
							cnt_q <= gpl_w;
						end
					end
					FLD_GAP: begin
						cnt_q <= cnt_q - 14'h0001;
						if (cnt_q == 14'h0001) begin
							r_q    <= r_q + 8'h01;
							secs_q <= secs_q + 8'h01;
							if (secs_q + 8'h01 == spt_q) begin
								fld_q <= FLD_FILL;
							end else begin
								ip_q <= 2'h0;
								{drq_q, irq_q} <= {~nd_q, nd_q};
								st_q <= S_FREQ;
							end
						end
					end
					default: fld_q <= FLD_FILL;
					endcase
				end
			end
			S_SSEC: begin
				if (index_i) begin
					idx_q <= idx_q + 2'h1;
					if (started_q || idx_q == 2'h1) begin
						abn_q <= 1'b1;
						st_q  <= S_DONE;
					end
				end else if (link.tc) begin
					st_q <= S_DONE;
				end else if (rd_id_i && rd_sec_i == r_q) begin
					started_q <= 1'b1;
					if (rd_del_i) begin
						cm_q <= 1'b1;
						if (!sk_q) begin
							st_q <= S_DONE;
						end else if (r_q == eot_q) begin
							sn_q <= 1'b1;
							st_q <= S_DONE;
						end else begin
							r_q <= r_next;
						end
					end else begin
						cnt_q    <= size_w;
						{fail_q, strict_q, hbv_q} <= 3'b000;
						tmr_q    <= ovr_lim;
						{drq_q, irq_q} <= {~nd_q, nd_q};
						st_q <= S_SBYTE;
					end
				end
			end
			S_SBYTE: begin
				tmr_q <= req_w ? tmr_q - 12'h001 : tmr_q;
				if (took_w) begin
					hb_q  <= link.hbyte;
					hbv_q <= 1'b1;
				end
				if (index_i) begin
					abn_q <= 1'b1;
					st_q  <= S_DONE;
				end else if ((req_w && tmr_q == 12'h000) || (rd_valid_i && !hbv_q)) begin
					ovr_q <= 1'b1;
					abn_q <= 1'b1;
					st_q  <= S_DONE;
				end else if (rd_valid_i) begin
					fail_q   <= fail_n;
					strict_q <= strict_n;
					hbv_q    <= 1'b0;
					cnt_q    <= cnt_q - 14'h0001;
					if (cnt_q == 14'h0001) begin
						if (!fail_n) begin
							sh_q <= ~strict_n;
							st_q <= S_DONE;
						end else if (r_q == eot_q || link.tc) begin
							sn_q <= ~link.tc;
							st_q <= S_DONE;
						end else begin
							r_q  <= r_next;
							st_q <= S_SSEC;
						end
					end else if (link.tc) begin
						st_q <= S_DONE;
					end else begin
						tmr_q <= ovr_lim;
						{drq_q, irq_q} <= {~nd_q, nd_q};
					end
				end
			end
			default: begin
				{drq_q, irq_q} <= 2'b00;
				link.done       <= 1'b1;
				link.st0        <= 8'(abn_q) << ST0_ABN;
				link.st1        <= 8'(ovr_q) << ST1_OVR;
				link.st2        <= (8'(cm_q) << ST2_CM) | (8'(sh_q) << ST2_SH) | (8'(sn_q) << ST2_SN);
				link.res_sector <= r_q;
				st_q            <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// [core/ffse_pkg.sv]
package ffse_pkg;
	// Clock and byte service limits
	localparam int          CLK_MHZ     = 100;
	localparam int          OVR_FM_US   = 27;
	localparam int          OVR_MFM_US  = 13;
	localparam logic [11:0] OVR_FM_CYC  = 12'(OVR_FM_US * CLK_MHZ);
	localparam logic [11:0] OVR_MFM_CYC = 12'(OVR_MFM_US * CLK_MHZ);

	// Command codes
	localparam logic [1:0] CMD_FMT     = 2'h0;
	localparam logic [1:0] CMD_SCAN_EQ = 2'h1;
	localparam logic [1:0] CMD_SCAN_LE = 2'h2;
	localparam logic [1:0] CMD_SCAN_GE = 2'h3;

	// Status bit positions
	localparam int ST0_ABN = 6;
	localparam int ST1_OVR = 4;
	localparam int ST2_CM  = 6;
	localparam int ST2_SH  = 3;
	localparam int ST2_SN  = 2;

	// Track field codes and bytes
	localparam logic [2:0] FLD_IDAM = 3'h0;
	localparam logic [2:0] FLD_ID   = 3'h1;
	localparam logic [2:0] FLD_DAM  = 3'h2;
	localparam logic [2:0] FLD_DATA = 3'h3;
	localparam logic [2:0] FLD_GAP  = 3'h4;
	localparam logic [2:0] FLD_FILL = 3'h5;
	localparam logic [7:0] AM_ID    = 8'hfe;
	localparam logic [7:0] AM_DATA  = 8'hfb;
	localparam logic [7:0] GAP_FM   = 8'hff;
	localparam logic [7:0] GAP_MFM  = 8'h4e;
	localparam logic [7:0] WILD     = 8'hff;
	localparam logic [13:0] SEC_BASE = 14'h0080;

	// Host register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PAR0 = 8'h04;
	localparam logic [7:0] REG_PAR1 = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_RES  = 8'h14;

	// Bytes per sector from size code
	function automatic logic [13:0] ffse_sec_bytes(input logic [2:0] n);
		return SEC_BASE << n;
	endfunction

	// Returns {fails, strictly unequal}; either byte at all ones always passes
	function automatic logic [1:0] ffse_cmp(input logic [1:0] c, input logic [7:0] d, input logic [7:0] h);
		logic wild;
		logic bad;
		wild = (d == WILD) | (h == WILD);
		bad  = (c == CMD_SCAN_EQ) ? (d != h) : (c == CMD_SCAN_LE) ? (d > h) : (d < h);
		return {~wild & bad, ~wild & (d != h)};
	endfunction
endpackage

// [core/ffse_if.sv]
`timescale 1ns/100ps
interface ffse_if (input wire logic clock_i, input wire logic rst_i);
	// Command phase
	logic       cmd_valid;
	logic       cmd_ready;
	logic [1:0] cmd;
	logic [7:0] size_code;
	logic [7:0] sectors_per_track;
	logic [7:0] gap_length;
	logic [7:0] fill;
	logic [7:0] sector;
	logic [7:0] end_of_track_sector;
	logic [7:0] sector_step;
	logic       skip_deleted_select;
	logic       non_dma_select;
	logic       mfm;
	// Byte service
	logic       dma_req;
	logic       int_req;
	logic       ack;
	logic [7:0] hbyte;
	logic       tc;
	// Result phase
	logic       done;
	logic [7:0] st0;
	logic [7:0] st1;
	logic [7:0] st2;
	logic [7:0] res_sector;

	modport dev (input clock_i, rst_i, cmd_valid, cmd, size_code, sectors_per_track, gap_length, fill,
		sector, end_of_track_sector, sector_step, skip_deleted_select, non_dma_select, mfm, ack, hbyte, tc,
		output cmd_ready, dma_req, int_req, done, st0, st1, st2, res_sector);
	modport host (input clock_i, rst_i, cmd_ready, dma_req, int_req, done, st0, st1, st2, res_sector,
		output cmd_valid, cmd, size_code, sectors_per_track, gap_length, fill, sector, end_of_track_sector,
		sector_step, skip_deleted_select, non_dma_select, mfm, ack, hbyte, tc);
endinterface

// [core/ffse_host.sv]
`timescale 1ns/100ps
module ffse_host
	import ffse_pkg::*;
(
	// Device link
	ffse_if.host      link,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	import ffse_pkg::*;

	logic       busy_q, done_q, full_q;
	logic [7:0] data_q;

	////////////////////////////////////////////////////////////////
	// Address decode, one wait state per access
	wire        acc_w  = psel & penable & ~pready;
	wire        wr_w   = psel & penable & pready & pwrite;
	wire        hit_w  = (paddr == REG_CTRL) | (paddr == REG_PAR0) | (paddr == REG_PAR1) |
	                     (paddr == REG_DATA) | (paddr == REG_STAT) | (paddr == REG_RES);
	wire        start_w = wr_w & (paddr == REG_CTRL) & pwdata[0];
	wire        req_w  = link.dma_req | link.int_req;
	wire [31:0] rd_w   = (paddr == REG_STAT) ? {link.st2, link.st1, link.st0, 4'h0, req_w, full_q, done_q, busy_q} :
	                     (paddr == REG_PAR0) ? {link.fill, link.gap_length, link.sectors_per_track, link.size_code} :
	                     (paddr == REG_PAR1) ? {8'h00, link.sector_step, link.end_of_track_sector, link.sector} :
	                     (paddr == REG_RES)  ? {24'h000000, link.res_sector} : 32'h00000000;

	////////////////////////////////////////////////////////////////
	// Bus answer
	always_ff @(posedge link.clock_i) begin
		if (link.rst_i) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= acc_w;
			pslverr <= acc_w & ~hit_w;
			if (acc_w && !pwrite) begin
				prdata <= rd_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Command registers and byte feed
	always_ff @(posedge link.clock_i) begin
		if (link.rst_i) begin
			{link.cmd_valid, link.cmd, link.skip_deleted_select, link.non_dma_select, link.mfm, link.tc} <= '0;
			{link.size_code, link.sectors_per_track, link.gap_length, link.fill} <= '0;
			{link.sector, link.end_of_track_sector, link.sector_step} <= '0;
			{link.ack, link.hbyte, busy_q, done_q, full_q, data_q} <= '0;
		end else begin
			link.ack <= 1'b0;
			if (link.cmd_valid && link.cmd_ready) begin
				link.cmd_valid <= 1'b0;
			end
			// Done is sticky; a finish in the same cycle as a new start still shows
			if (start_w) begin
				done_q <= link.done;
			end else if (link.done) begin
				done_q <= 1'b1;
			end
			if (link.done) begin
				busy_q <= 1'b0;
			end
			if (wr_w && paddr == REG_CTRL) begin
				link.tc <= pwdata[6];
				if (pwdata[0] && !busy_q) begin
					link.cmd_valid           <= 1'b1;
					link.cmd                 <= pwdata[2:1];
					link.skip_deleted_select <= pwdata[3];
					link.non_dma_select      <= pwdata[4];
					link.mfm                 <= pwdata[5];
					busy_q                   <= 1'b1;
					full_q                   <= 1'b0;
				end
			end
			if (wr_w && paddr == REG_PAR0) begin
				{link.fill, link.gap_length, link.sectors_per_track, link.size_code} <= pwdata;
			end
			if (wr_w && paddr == REG_PAR1) begin
				{link.sector_step, link.end_of_track_sector, link.sector} <= pwdata[23:0];
			end
			// One byte slot; software must refill it within the service time
			if (req_w && full_q && !link.ack) begin
				link.ack   <= 1'b1;
				link.hbyte <= data_q;
				full_q     <= 1'b0;
			end else if (wr_w && paddr == REG_DATA) begin
				data_q <= pwdata[7:0];
				full_q <= 1'b1;
			end
		end
	end
endmodule

// [dv/ffse_properties.sv]
`timescale 1ns/100ps
module ffse_properties
	import ffse_pkg::*;
(
	// Clock and reset
	input wire logic       clock_i,
	input wire logic       rst_i,
	// Command phase
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [1:0] cmd,
	input wire logic [7:0] size_code,
	input wire logic [7:0] sector,
	input wire logic       mfm,
	input wire logic       non_dma_select,
	// Byte service
	input wire logic       dma_req,
	input wire logic       int_req,
	input wire logic       ack,
	// Result phase
	input wire logic       done,
	input wire logic [7:0] st0,
	input wire logic [7:0] st1,
	input wire logic [7:0] st2,
	input wire logic [7:0] res_sector
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic [9:0] acks_q;

	////////////////////////////////////////////////////////////////
	// Acks since the last take; four of them make one sector
	always_ff @(posedge clock_i) begin
		if (rst_i || (cmd_valid && cmd_ready)) begin
			acks_q <= 10'h000;
		end else if (ack) begin
			acks_q <= acks_q + 10'h001;
		end
	end

	sequence s_small_mfm;
		cmd_valid && cmd_ready && mfm && size_code == 8'h00;
	endsequence
	sequence s_refused;
		##[1:6] done && st0[ST0_ABN];
	endsequence

	////////////////////////////////////////////////////////////////
	chk_mfm_small_refused: assert property (s_small_mfm |-> s_refused)
		else $error("small sector in mfm not refused");
	chk_take_goes_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready ##[0:1] !cmd_valid)
		else $error("take did not leave idle");
	chk_dma_mode_only: assert property (dma_req |-> !non_dma_select)
		else $error("dma request in interrupt mode");
	chk_int_mode_only: assert property (int_req |-> non_dma_select)
		else $error("interrupt request in dma mode");
	chk_ack_on_req: assert property (ack |-> dma_req || int_req)
		else $error("ack without request");
	chk_req_drops: assert property (ack && cmd != CMD_FMT |-> ##2 !(dma_req || int_req))
		else $error("scan request held after ack");
	chk_fmt_req_held: assert property (ack && cmd == CMD_FMT && acks_q[1:0] != 2'h3
		|-> ##2 (dma_req || int_req))
		else $error("format request dropped inside a sector");
	chk_overrun_code: assert property (done && st1[ST1_OVR] |-> st0[ST0_ABN] && !st0[7])
		else $error("overrun without abnormal code");
	chk_flags_exclusive: assert property (done && cmd != CMD_FMT |-> !(st2[ST2_SH] && st2[ST2_SN]))
		else $error("hit and not met together");
	chk_fmt_sector_count: assert property (done && cmd == CMD_FMT && !st0[ST0_ABN]
		|-> acks_q[1:0] == 2'h0 && res_sector == sector + acks_q[9:2])
		else $error("format sector number wrong");
	chk_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
	import ffse_pkg::*;
	// Stimulus and observed pins
	logic        clock_i;
	logic        rst_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        wr_take_i = 1'h0;
	logic        wr_en_o;
	logic [2:0]  wr_field_o;
	logic [7:0]  wr_byte_o;
	logic        index_i;
	logic        rd_id_i;
	logic [7:0]  rd_sec_i;
	logic        rd_del_i;
	logic        rd_valid_i;
	logic [7:0]  rd_byte_i;
	// Tallies and last results
	logic [31:0] rd;
	logic        er;
	logic [31:0] st;
	int          errors = 0;
	int          n_tests = 0;
	int          n_idam = 0;
	int          n_data = 0;
	int          n_gap = 0;
	int          n_end = 0;
	logic [7:0]  idq[$];

	////////////////////////////////////////////////////////////////
	ffse_if i_ffse_if (.clock_i(clock_i), .rst_i(rst_i));
	ffse_host i_ffse_host (.link(i_ffse_if), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	ffse_dev i_ffse_dev (.link(i_ffse_if), .wr_take_i(wr_take_i), .wr_en_o(wr_en_o), .wr_field_o(wr_field_o),
		.wr_byte_o(wr_byte_o), .index_i(index_i), .rd_id_i(rd_id_i), .rd_sec_i(rd_sec_i), .rd_del_i(rd_del_i),
		.rd_valid_i(rd_valid_i), .rd_byte_i(rd_byte_i));
	ffse_properties i_props (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid(i_ffse_if.cmd_valid),
		.cmd_ready(i_ffse_if.cmd_ready), .cmd(i_ffse_if.cmd), .size_code(i_ffse_if.size_code),
		.sector(i_ffse_if.sector), .mfm(i_ffse_if.mfm), .non_dma_select(i_ffse_if.non_dma_select),
		.dma_req(i_ffse_if.dma_req), .int_req(i_ffse_if.int_req), .ack(i_ffse_if.ack), .done(i_ffse_if.done),
		.st0(i_ffse_if.st0), .st1(i_ffse_if.st1), .st2(i_ffse_if.st2), .res_sector(i_ffse_if.res_sector));

	// Clock at 100 MHz
	initial begin
		clock_i = 1'h0;
		forever #5 clock_i = ~clock_i;
	end

	// Encoder stand-in: takes every other cycle, tallies fields
	always @(posedge clock_i) begin
		wr_take_i <= wr_en_o & ~wr_take_i;
		if (wr_take_i && wr_en_o) begin
			case (wr_field_o)
				FLD_IDAM: n_idam += (wr_byte_o === AM_ID);
				FLD_ID: idq.push_back(wr_byte_o);
				FLD_DATA: n_data += (wr_byte_o === 8'ha5);
				FLD_GAP: n_gap += (wr_byte_o === GAP_FM);
				FLD_FILL: n_end++;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'h1;
		do @(posedge clock_i); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
		do apb(1'h0, REG_STAT, 32'h0); while ((rd & m) !== v);
	endtask

	// Waits for a request with the slot free, then until the byte is taken
	task automatic send_byte(input logic [7:0] b);
		wait_stat(32'hc, 32'h8);
		apb(1'h1, REG_DATA, {24'h0, b});
		wait_stat(32'h4, 32'h0);
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] c, input logic sk, input logic nd, input logic mf);
		return {25'h0, 1'h0, mf, nd, sk, c, 1'h1};
	endfunction

	task automatic start(input logic [31:0] c, input logic [31:0] p0, input logic [31:0] p1);
		apb(1'h1, REG_PAR0, p0);
		apb(1'h1, REG_PAR1, p1);
		apb(1'h1, REG_CTRL, c);
	endtask

	task automatic finish_cmd;
		wait_stat(32'h2, 32'h2);
		apb(1'h0, REG_STAT, 32'h0);
		st = rd;
		apb(1'h0, REG_RES, 32'h0);
	endtask

	task automatic pulse(input logic [1:0] k, input logic [7:0] v, input logic del);
		@(posedge clock_i);
		index_i <= (k == 2'h0);
		rd_id_i <= (k == 2'h1);
		rd_valid_i <= (k == 2'h2);
		rd_sec_i <= v;
		rd_byte_i <= v;
		rd_del_i <= del;
		@(posedge clock_i);
		index_i <= 1'h0;
		rd_id_i <= 1'h0;
		rd_valid_i <= 1'h0;
	endtask

	// Host byte then disk byte; disk byte at wi is all ones
	task automatic scan_bytes(input int n, input logic [7:0] d, input logic [7:0] h, input int wi);
		for (int i = 0; i < n; i++) begin
			send_byte(h);
			pulse(2'h2, (i == wi) ? WILD : d, 1'h0);
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_refuse;
		apb(1'h0, 8'h18, 32'h0);
		chk(16'(er), 16'h1);
		start(ctl(CMD_FMT, 1'h0, 1'h0, 1'h1), 32'h0, 32'h1);
		finish_cmd();
		chk(16'(st[15:8] & 8'hc0), 16'h40);
	endtask

	task automatic t_idx_abort;
		start(ctl(CMD_SCAN_EQ, 1'h0, 1'h0, 1'h0), 32'h0, 32'h00010201);
		pulse(2'h0, 8'h0, 1'h0);
		pulse(2'h0, 8'h0, 1'h0);
		finish_cmd();
		chk(16'(st[15:8] & 8'hc0), 16'h40);
	endtask

	task automatic t_format;
		start(ctl(CMD_FMT, 1'h0, 1'h0, 1'h0), 32'ha5030201, 32'h00010207);
		apb(1'h0, REG_STAT, 32'h0);
		chk(16'(rd[3]), 16'h0);
		pulse(2'h0, 8'h0, 1'h0);
		for (int i = 0; i < 8; i++) send_byte(8'(8'h30 + i));
		wait (n_end > 0);
		apb(1'h0, REG_STAT, 32'h0);
		chk(16'(rd[1:0]), 16'h1);
		pulse(2'h0, 8'h0, 1'h0);
		finish_cmd();
		chk(16'(rd[7:0]), 16'h9);
		chk(16'(st[15:8]), 16'h0);
		chk(16'(n_idam), 16'h2);
		chk(16'(n_data), 16'h200);
		chk(16'(n_gap), 16'h6);
		for (int i = 0; i < 8; i++) chk(16'(idq[i]), 16'(8'h30 + i));
	endtask

	task automatic t_overrun;
		start(ctl(CMD_SCAN_EQ, 1'h0, 1'h0, 1'h0), 32'h0, 32'h00010201);
		pulse(2'h1, 8'h1, 1'h0);
		pulse(2'h2, 8'h12, 1'h0);
		finish_cmd();
		chk(16'({st[15:8] & 8'hc0, st[23:16] & 8'h10}), 16'h4010);
	endtask

	task automatic t_scan_eq;
		start(ctl(CMD_SCAN_EQ, 1'h0, 1'h1, 1'h0), 32'h0, 32'h00010301);
		pulse(2'h1, 8'h1, 1'h0);
		scan_bytes(128, 8'h10, 8'h20, -1);
		pulse(2'h1, 8'h2, 1'h0);
		scan_bytes(128, 8'h44, 8'h44, 7);
		finish_cmd();
		chk(16'(st[31:24] & 8'h0c), 16'h08);
		chk(16'(rd[7:0]), 16'h2);
	endtask

	task automatic t_scan_le;
		start(ctl(CMD_SCAN_LE, 1'h1, 1'h0, 1'h0), 32'h0, 32'h00020301);
		pulse(2'h1, 8'h1, 1'h1);
		apb(1'h0, REG_STAT, 32'h0);
		chk(16'(rd[3]), 16'h0);
		pulse(2'h1, 8'h3, 1'h0);
		scan_bytes(128, 8'h05, 8'h80, -1);
		finish_cmd();
		chk(16'(st[31:24] & 8'h4c), 16'h40);
		chk(16'(rd[7:0]), 16'h3);
	endtask

	task automatic t_scan_ge;
		start(ctl(CMD_SCAN_GE, 1'h0, 1'h0, 1'h1), 32'h00000001, 32'h00010404);
		pulse(2'h1, 8'h4, 1'h0);
		scan_bytes(256, 8'h01, 8'hfe, -1);
		finish_cmd();
		chk(16'(st[31:24] & 8'h0c), 16'h04);
	endtask

	// Terminal count mid-sector: one byte may still be finished
	task automatic t_tc;
		start(ctl(CMD_SCAN_EQ, 1'h0, 1'h0, 1'h0), 32'h0, 32'h00010401);
		pulse(2'h1, 8'h1, 1'h0);
		scan_bytes(3, 8'h33, 8'h33, -1);
		apb(1'h1, REG_CTRL, 32'h42);
		do apb(1'h0, REG_STAT, 32'h0); while (rd[3:1] === 3'h0);
		if (rd[3:1] === 3'h4) scan_bytes(1, 8'h33, 8'h33, -1);
		finish_cmd();
		chk(16'({rd[7:0], st[31:24] & 8'h0c}), 16'h0100);
	endtask

	task automatic conclude;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence; index counting must restart after the aborted scan
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{index_i, rd_id_i, rd_sec_i, rd_del_i, rd_valid_i, rd_byte_i} = '0;
		rst_i = 1'h1;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'h0;
		t_refuse();
		t_idx_abort();
		t_format();
		t_overrun();
		t_scan_eq();
		t_scan_le();
		t_scan_ge();
		t_tc();
		conclude();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clock_i);
		errors++;
		conclude();
	end
endmodule
